// ### sfrc_pkg.sv
// Purpose: Shared constants for the serial flash reset control block.
// Assumes: Core clock of 250 MHz (4 ns period).
// Notes:   Times are kept in their own unit; cycle counts derive from them.
//
// Behaviour
// - Reset during write leaves target unreliable
// - Hardware reset ignored during software reset
// - Reset pins ignored during power-up
// - Data3 pin resets when qualified by mode
// - Low over 200 ns starts hardware reset
// - Data3 low ignored during select-high interval
// - Failed power-up makes reset redo power-up
// - Arm 66h then 99h performs soft reset
// - Nonvolatile bit clear disables pin reset
// - Reset aborts, tri-states, rejects commands; code raises abort_op on hardware reset only
// - Device drives data3 high after quad reads
// - Select-high interval 20 ns read, 50 other
// - Volatile bits enable pin reset, quad
`default_nettype none
package sfrc_pkg;
    // ******************************************************************
    // Clock and times
    // ******************************************************************
    localparam int CLK_PERIOD_PS          = 4000;
    localparam int PULSE_WIDTH_NS         = 200;
    localparam int COMPLETION_US          = 100;
    localparam int HIGH_SETUP_NS          = 50;
    localparam int HOLD_DELAY_NS          = 150;
    localparam int CS_HIGH_READ_NS        = 20;
    localparam int CS_HIGH_OTHER_NS       = 50;
    localparam int POWER_UP_US            = 300;
    // Least times round up to whole cycles.
    localparam int PULSE_WIDTH_CYC  = (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int COMPLETION_CYC   = (COMPLETION_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HIGH_SETUP_CYC   = (HIGH_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_DELAY_CYC   = (HOLD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CS_READ_CYC      = (CS_HIGH_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CS_OTHER_CYC     = (CS_HIGH_OTHER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWER_UP_CYC     = (POWER_UP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W            = 20;
    // ******************************************************************
    // Field positions and instruction codes
    // ******************************************************************
    localparam int QUAD_BIT          = 1;
    localparam int FOUR_LINE_BIT     = 3;
    localparam int PIN_RESET_BIT     = 7;
    localparam logic [7:0] SOFT_RESET_ARM_INSTR = 8'h66;
    localparam logic [7:0] SOFT_RESET_INSTR     = 8'h99;
    // Sequencer states.
    typedef enum logic [2:0] {
        SFRC_POWER_UP   = 3'b000,
        SFRC_HELD       = 3'b001,
        SFRC_HW_RESET   = 3'b010,
        SFRC_SW_RESET   = 3'b011,
        SFRC_READY      = 3'b100
    } sfrc_state_t;
endpackage
`default_nettype wire

// ### sfrc_link_if.sv
// Purpose: Carries link-side events from the link domain into the core.
// Assumes: Toggles cross by two-flop synchronisers in the core.
// Notes:   Each toggle flips once per event.
`timescale 1ns/1ns
`default_nettype none
interface sfrc_link_if;
    logic       arm_tgl;     // Flips when the arm instruction completes.
    logic       reset_tgl;   // Flips when an armed reset instruction completes.
    logic       read_last;   // Level: last instruction was a read.
    logic       quad_out;    // Level: last instruction returned data on four lines.
    modport link (output arm_tgl, output reset_tgl, output read_last, output quad_out);
    modport core (input arm_tgl, input reset_tgl, input read_last, input quad_out);
endinterface
`default_nettype wire

// ### sfrc_link_rx.sv
// Purpose: Captures instruction bytes on the serial clock.
// Assumes: Mode 0 sampling on single data line; chip select low frames it.
// Notes:   The serial clock may stop between frames; shift and bit count clear when select rises.
`timescale 1ns/1ns
`default_nettype none
module sfrc_link_rx (
    // Link pins
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  data0_in,
    input  wire logic  rx_enable,
    // Core side
    sfrc_link_if.link  lnk
);
    logic [7:0] shreg;    // Bits shifted in so far.
    logic [3:0] bitcnt;   // Bits received in this frame.
    logic       armed;    // Arm instruction seen in the previous frame.
    logic [7:0] next_byte;

    assign next_byte = {shreg[6:0], data0_in};

    // Shift in bits; the count restarts asynchronously when select rises,
    // because no clock edge is promised after a frame.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            shreg  <= 8'h00;
            bitcnt <= 4'h0;
        end else begin
            shreg  <= next_byte;
            bitcnt <= (bitcnt == 4'h8) ? bitcnt : bitcnt + 4'h1;
        end
    end

    // Decode the first byte of each frame on its eighth edge.
    always_ff @(posedge sclk or negedge rx_enable) begin
        if (!rx_enable) begin
            armed         <= 1'b0;
            lnk.arm_tgl   <= 1'b0;
            lnk.reset_tgl <= 1'b0;
            lnk.read_last <= 1'b0;
            lnk.quad_out  <= 1'b0;
        end else if (!cs_n && bitcnt == 4'h7) begin
            armed          <= (next_byte == sfrc_pkg::SOFT_RESET_ARM_INSTR);
            lnk.read_last  <= (next_byte == 8'h03) || (next_byte == 8'h0B)
                              || (next_byte == 8'hEB) || (next_byte == 8'h6B);
            lnk.quad_out   <= (next_byte == 8'hEB) || (next_byte == 8'h6B);
            if (next_byte == sfrc_pkg::SOFT_RESET_ARM_INSTR) begin
                lnk.arm_tgl <= ~lnk.arm_tgl;
            end
            if (armed && next_byte == sfrc_pkg::SOFT_RESET_INSTR) begin
                lnk.reset_tgl <= ~lnk.reset_tgl;
            end
        end
    end
endmodule
`default_nettype wire

// ### sfrc_reset_ctrl.sv
// Purpose: Reset sequencer for a serial multi-line flash device.
// Assumes: Pins are asynchronous to core_clk and pass two flops first.
// Notes:   One reset input should be used in a system; both are served.
`timescale 1ns/1ns
`default_nettype none
module sfrc_reset_ctrl #(
    parameter int POWER_UP_CYC   = sfrc_pkg::POWER_UP_CYC,
    parameter int COMPLETION_CYC = sfrc_pkg::COMPLETION_CYC
) (
    // Core clock and reset
    input  wire logic  core_clk,
    input  wire logic  nrst,
    // Link pins
    input  wire logic  sclk,
    input  wire logic  cs_n,
    input  wire logic  data0_in,
    input  wire logic  reset_pin_n,
    input  wire logic  data3_or_reset_pin_in,
    output logic       data3_or_reset_pin_out,
    output logic       data3_or_reset_pin_oe,
    // Configuration bits
    input  wire logic  volatile_config_one_quad,
    input  wire logic  volatile_config_two_four_line,
    input  wire logic  volatile_config_two_pin_reset,
    input  wire logic  nonvolatile_config_two_pin_reset,
    input  wire logic  power_up_ok,
    input  wire logic  write_busy,
    // Status
    output logic       in_reset,
    output logic       cmd_reject,
    output logic       outputs_off,
    output logic       abort_op,
    output logic       redo_needed,
    output logic       regs_restore,
    output logic       full_power_up
);
    // ******************************************************************
    // Synchronisers
    // ******************************************************************
    logic [1:0] rst_s, d3_s, cs_s, arm_s, rst_t, rd_s, qo_s;
    logic       rst_t_d;
    logic       rx_enable;   // Link decode runs only outside reset.
    sfrc_link_if lnk ();

    sfrc_link_rx u_rx (
        .sclk      (sclk),
        .cs_n      (cs_n),
        .data0_in  (data0_in),
        .rx_enable (rx_enable),
        .lnk       (lnk)
    );

    // Two flops on the reset, data3 and select pins and on every cross-domain level.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s <= 2'h3;
            d3_s  <= 2'h3;
            cs_s  <= 2'h3;
            arm_s <= 2'h0;
            rst_t <= 2'h0;
            rd_s  <= 2'h0;
            qo_s  <= 2'h0;
        end else begin
            rst_s <= {rst_s[0], reset_pin_n};
            d3_s  <= {d3_s[0], data3_or_reset_pin_in};
            cs_s  <= {cs_s[0], cs_n};
            arm_s <= {arm_s[0], lnk.arm_tgl};
            rst_t <= {rst_t[0], lnk.reset_tgl};
            rd_s  <= {rd_s[0], lnk.read_last};
            qo_s  <= {qo_s[0], lnk.quad_out};
        end
    end

    // ******************************************************************
    // Select-high qualification
    // ******************************************************************
    logic [7:0] cs_cnt;      // Cycles since select rose.
    logic       cs_qual;     // Select high longer than its interval.
    logic [7:0] cs_need;

    // the interval depends on whether the last instruction was a read.
    assign cs_need = rd_s[1] ? 8'(sfrc_pkg::CS_READ_CYC) : 8'(sfrc_pkg::CS_OTHER_CYC);

    // Count select-high time; a low select restarts it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cs_cnt <= 8'h00;
        end else if (!cs_s[1]) begin
            cs_cnt <= 8'h00;
        end else if (cs_cnt != 8'hFF) begin
            cs_cnt <= cs_cnt + 8'h01;
        end
    end
    assign cs_qual = cs_s[1] && (cs_cnt > cs_need);

    // ******************************************************************
    // Reset qualification
    // ******************************************************************
    logic quad_on, pin_reset_on, d3_qual, any_low;
    logic [7:0] low_cnt;     // Cycles the qualified reset has been low.
    logic [7:0] high_cnt;    // Cycles the reset inputs have been high.
    logic       hw_trigger;

    assign quad_on      = volatile_config_one_quad && volatile_config_two_four_line;
    // both the volatile and nonvolatile bits must enable it.
    assign pin_reset_on = volatile_config_two_pin_reset
                          && nonvolatile_config_two_pin_reset;
    // qualified when quad off, or select held past its interval.
    assign d3_qual = pin_reset_on && (!quad_on || cs_qual);
    assign any_low = !rst_s[1] || (d3_qual && !d3_s[1]);

    // Measure low pulse length; above 200 ns triggers.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 8'h00;
        end else if (!any_low) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    assign hw_trigger = (low_cnt > 8'(sfrc_pkg::PULSE_WIDTH_CYC));

    // Measure high time on both inputs for re-arming.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            high_cnt <= 8'h00;
        end else if (!rst_s[1] || !d3_s[1]) begin
            high_cnt <= 8'h00;
        end else if (high_cnt != 8'hFF) begin
            high_cnt <= high_cnt + 8'h01;
        end
    end

    // ******************************************************************
    // Sequencer
    // ******************************************************************
    sfrc_pkg::sfrc_state_t state;
    logic [31:0] tcnt;       // Time spent in the current timed state.
    logic        armed_hw;   // Inputs were high long enough since last reset.
    logic        sw_req;

    assign sw_req = (rst_t[1] != rst_t_d);

    // Main state flow from power-up through resets to ready.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state   <= sfrc_pkg::SFRC_POWER_UP;
            tcnt    <= 32'h0000_0000;
            rst_t_d <= 1'b0;
        end else begin
            rst_t_d <= rst_t[1];
            tcnt    <= tcnt + 32'h0000_0001;
            case (state)
                sfrc_pkg::SFRC_POWER_UP: begin
                    // pins are not looked at until the interval ends.
                    if (tcnt >= 32'(POWER_UP_CYC - 1)) begin
                        tcnt  <= 32'h0000_0000;
                        state <= any_low ? sfrc_pkg::SFRC_HELD : sfrc_pkg::SFRC_READY;
                    end
                end
                sfrc_pkg::SFRC_HELD: begin
                    if (!any_low) begin
                        state <= sfrc_pkg::SFRC_READY;
                    end
                    tcnt <= 32'h0000_0000;
                end
                sfrc_pkg::SFRC_HW_RESET, sfrc_pkg::SFRC_SW_RESET: begin
                    if (tcnt >= 32'(COMPLETION_CYC - 1)) begin
                        tcnt  <= 32'h0000_0000;
                        state <= sfrc_pkg::SFRC_READY;
                    end
                    // a hardware request during soft reset is dropped.
                end
                sfrc_pkg::SFRC_READY: begin
                    tcnt <= 32'h0000_0000;
                    if (hw_trigger && armed_hw) begin
                        // without a good power-up, redo the whole thing.
                        state <= power_up_ok ? sfrc_pkg::SFRC_HW_RESET
                                             : sfrc_pkg::SFRC_POWER_UP;
                    end else if (sw_req && rst_s[1] && d3_s[1]) begin
                        state <= sfrc_pkg::SFRC_SW_RESET;
                    end
                end
                default: begin
                    state <= sfrc_pkg::SFRC_POWER_UP;
                end
            endcase
        end
    end

    // Re-arm only after the inputs stayed high for the setup time.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            armed_hw <= 1'b0;
        end else if (state != sfrc_pkg::SFRC_READY) begin
            armed_hw <= 1'b0;
        end else if (high_cnt >= 8'(sfrc_pkg::HIGH_SETUP_CYC)) begin
            armed_hw <= 1'b1;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    logic entering;
    assign entering = (state == sfrc_pkg::SFRC_READY) && hw_trigger && armed_hw;

    // Status flags track the sequencer, all registered.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_reset      <= 1'b1;
            cmd_reject    <= 1'b1;
            outputs_off   <= 1'b1;
            abort_op      <= 1'b0;
            regs_restore  <= 1'b0;
            full_power_up <= 1'b1;
            rx_enable     <= 1'b0;
        end else begin
            in_reset      <= (state != sfrc_pkg::SFRC_READY);
            cmd_reject    <= (state != sfrc_pkg::SFRC_READY);
            outputs_off   <= (state == sfrc_pkg::SFRC_HW_RESET)
                             || (state != sfrc_pkg::SFRC_READY);
            abort_op      <= entering;
            regs_restore  <= entering && power_up_ok;
            full_power_up <= (state == sfrc_pkg::SFRC_POWER_UP);
            rx_enable     <= (state == sfrc_pkg::SFRC_READY);
        end
    end

    // Flag an interrupted write so it can be reissued.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            redo_needed <= 1'b0;
        end else if (entering && write_busy) begin
            redo_needed <= 1'b1;
        end else if (!cs_s[1]) begin
            redo_needed <= 1'b0;
        end
    end

    // Drive data3 high after a quad read until select-high qualifies;
    // this keeps a floating line from faking a reset.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data3_or_reset_pin_out <= 1'b0;
            data3_or_reset_pin_oe  <= 1'b0;
        end else begin
            data3_or_reset_pin_out <= 1'b1;
            data3_or_reset_pin_oe  <= qo_s[1] && quad_on && pin_reset_on && cs_s[1]
                                      && !cs_qual && (state == sfrc_pkg::SFRC_READY);
        end
    end
endmodule
`default_nettype wire

// ### sfrc_checker.sv
// Purpose: Port-level checks on the reset sequencer.
// Assumes: All checks sit in the core clock domain.
// Notes:   Counts come from the parameters passed by the bind.
`timescale 1ns/1ns
`default_nettype none
module sfrc_checker #(
    parameter int POWER_UP_CYC   = 200,
    parameter int COMPLETION_CYC = 500
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Pins and levels
    input wire logic reset_pin_n,
    input wire logic cs_n,
    input wire logic write_busy,
    input wire logic data3_or_reset_pin_out,
    input wire logic data3_or_reset_pin_oe,
    // Status
    input wire logic in_reset,
    input wire logic cmd_reject,
    input wire logic outputs_off,
    input wire logic abort_op,
    input wire logic redo_needed,
    input wire logic regs_restore,
    input wire logic full_power_up
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ************************************************************
    // Helper counters
    // ************************************************************
    logic [19:0] hw_cnt; // Cycles since a hardware reset began.
    logic [19:0] pu_cnt; // Cycles of the current power-up run.
    // A zero count marks that no hardware reset is being timed.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hw_cnt <= '0;
        end else if (abort_op) begin
            hw_cnt <= 20'h00001;
        end else if (in_reset && hw_cnt != 0) begin
            hw_cnt <= hw_cnt + 20'h00001;
        end else begin
            hw_cnt <= '0;
        end
    end
    // Counts only while the power-up interval is flagged.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt <= '0;
        end else begin
            pu_cnt <= full_power_up ? pu_cnt + 20'h00001 : '0;
        end
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_pin_fall;
        $fell(reset_pin_n) && !in_reset && !full_power_up;
    endsequence
    a_pwr_no_abort: assert property (full_power_up |-> !abort_op)
        else $error("abort during power-up");
    a_short_low_ignored: assert property (s_pin_fall |-> !abort_op [*8])
        else $error("reset taken before pulse width");
    a_abort_sets_reset: assert property (abort_op |-> ##[0:1] in_reset)
        else $error("abort without reset state");
    a_flags_move_together: assert property (in_reset == cmd_reject && in_reset == outputs_off)
        else $error("reset flags differ");
    a_restore_at_start: assert property (regs_restore |-> abort_op)
        else $error("restore outside reset start");
    a_reset_span: assert property ($fell(in_reset) && hw_cnt != 0 |->
        hw_cnt inside {[COMPLETION_CYC - 2 : COMPLETION_CYC + 2]})
        else $error("hardware reset length wrong");
    a_power_up_span: assert property ($fell(full_power_up) |->
        pu_cnt inside {[POWER_UP_CYC - 1 : POWER_UP_CYC + 4]})
        else $error("power-up length wrong");
    a_drive_only_high: assert property (data3_or_reset_pin_oe |-> data3_or_reset_pin_out && cs_n)
        else $error("bad data3 drive");
    a_drive_bounded: assert property ($rose(data3_or_reset_pin_oe) |-> ##[1:24] !data3_or_reset_pin_oe)
        else $error("data3 driven too long");
    a_redo_on_write: assert property (abort_op && write_busy |-> ##[0:2] redo_needed)
        else $error("redo flag missing");
endmodule
bind sfrc_reset_ctrl sfrc_checker #(
    .POWER_UP_CYC  (POWER_UP_CYC),
    .COMPLETION_CYC(COMPLETION_CYC)
) chk_u (.core_clk, .nrst, .reset_pin_n, .cs_n, .write_busy, .data3_or_reset_pin_out,
    .data3_or_reset_pin_oe, .in_reset, .cmd_reject, .outputs_off, .abort_op,
    .redo_needed, .regs_restore, .full_power_up);
`default_nettype wire

// ### sfrc_host_model.sv
// Purpose: Behavioural host controller sending instruction frames.
// Assumes: Mode 0, single data line, 48 ns serial clock.
// Notes:   The serial clock stands still outside frames.
`timescale 1ns/1ns
`default_nettype none
module sfrc_host_model (
    // Requests from the bench
    input  wire logic       start,
    input  wire logic [7:0] code,
    input  wire logic [3:0] nbytes,
    // Link pins
    output logic            sclk,
    output logic            cs_n,
    output logic            data0,
    output logic            busy
);
    // Idle: deselected, clock low, data line parked inverted.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        data0 = 1'b1;
        busy = 1'b0;
    end
    // One frame per start edge; the code is repeated to pad long frames.
    always @(posedge start) begin
        busy = 1'b1;
        cs_n = 1'b0;
        for (int b = 0; b < nbytes; b++) begin
            for (int i = 7; i >= 0; i--) begin
                data0 = code[i];
                #24 sclk = 1'b1;
                #24 sclk = 1'b0;
            end
        end
        #10 cs_n = 1'b1;
        data0 = ~data0;
        // Keep select high long enough before the next frame.
        #60 busy = 1'b0;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Short power-up and completion counts for run time.
// Notes:   A watcher pairs each abort pulse with a queued note.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    localparam int PU = 200;  // Shortened power-up count.
    localparam int CP = 500;  // Shortened completion count.
    // ************************************************************
    // Signals
    // ************************************************************
    logic core_clk, nrst, sclk, cs_n, data0, busy, start, d3_wire;
    logic reset_pin_n, host_d3, host_d3_oe, d3_out, d3_oe, quad, four, vpin, nvpin;
    logic power_up_ok, write_busy, in_reset, cmd_reject, outputs_off, abort_op;
    logic redo_needed, regs_restore, full_power_up, loose;
    logic [7:0] code, rnd;
    logic [3:0] nbytes;
    logic [1:0] exp_q[$]; // Expected {restore, redo} per hardware reset.
    int n_fail, n_compared;
    // The data3 line has a pull-up when nobody drives it.
    assign d3_wire = d3_oe ? d3_out : (host_d3_oe ? host_d3 : 1'b1);
    always #2 core_clk = ~core_clk;
    sfrc_host_model host_u (.start(start), .code(code), .nbytes(nbytes), .sclk(sclk),
        .cs_n(cs_n), .data0(data0), .busy(busy));
    sfrc_reset_ctrl #(.POWER_UP_CYC(PU), .COMPLETION_CYC(CP)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .data0_in(data0),
        .reset_pin_n(reset_pin_n), .data3_or_reset_pin_in(d3_wire),
        .data3_or_reset_pin_out(d3_out), .data3_or_reset_pin_oe(d3_oe),
        .volatile_config_one_quad(quad), .volatile_config_two_four_line(four),
        .volatile_config_two_pin_reset(vpin), .nonvolatile_config_two_pin_reset(nvpin),
        .power_up_ok(power_up_ok), .write_busy(write_busy), .in_reset(in_reset),
        .cmd_reject(cmd_reject), .outputs_off(outputs_off), .abort_op(abort_op),
        .redo_needed(redo_needed), .regs_restore(regs_restore),
        .full_power_up(full_power_up));
    // Eight-bit shift register for pulse lengths.
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic stop_test();
        $display("counts: compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Low pulse on one reset input, then a high gap well over 13 cycles.
    task automatic pulse(input logic on_d3, input int len);
        @(posedge core_clk);
        if (on_d3) begin
            host_d3 <= 1'b0;
            host_d3_oe <= 1'b1;
        end else begin
            reset_pin_n <= 1'b0;
        end
        repeat (len) @(posedge core_clk);
        reset_pin_n <= 1'b1;
        host_d3 <= 1'b1;
        repeat (20) @(posedge core_clk);
        host_d3_oe <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] c, input logic [3:0] n);
        @(posedge core_clk);
        code <= c;
        nbytes <= n;
        start <= 1'b1;
        repeat (4) @(posedge core_clk);
        start <= 1'b0;
        for (int i = 0; i < 2000 && busy; i++) @(posedge core_clk);
    endtask
    // Waits for the reset state to end, bounded.
    task automatic wait_ready(input int lim);
        for (int i = 0; i < lim && in_reset !== 1'b0; i++) @(posedge core_clk);
        `CHK("in_reset", 1'b0, in_reset)
    endtask
    // ************************************************************
    // Watcher: each abort pulse takes the oldest note.
    // ************************************************************
    always @(posedge core_clk) begin
        if (abort_op === 1'b1 && !loose) begin
            if (exp_q.size() == 0) begin
                `CHK("abort_op", 1'b0, abort_op)
            end else begin
                `CHK("regs_restore", exp_q[0][1], regs_restore)
                repeat (3) @(posedge core_clk);
                `CHK("redo_needed", exp_q[0][0], redo_needed)
                void'(exp_q.pop_front());
            end
        end
    end
    // Stops a hung run.
    initial begin
        #120000;
        n_fail++;
        stop_test();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {core_clk, nrst, start, write_busy, host_d3, host_d3_oe, loose} = '0;
        {reset_pin_n, quad, four, vpin, nvpin, power_up_ok} = '1;
        {n_fail, n_compared, code, nbytes} = '0;
        rnd = 8'h55;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK("full_power_up", 1'b1, full_power_up)
        pulse(1'b0, 220);
        wait_ready(400);
        $display("test power-up done");
        for (int k = 0; k < 2; k++) begin
            rnd = lfsr(rnd);
            write_busy <= k[0];
            exp_q.push_back({1'b1, k[0]});
            pulse(1'b0, 55 + int'(rnd[2:0]));
            `CHK("cmd_reject", 1'b1, cmd_reject)
            wait_ready(CP + 100);
        end
        write_busy <= 1'b0;
        pulse(1'b0, 30);
        frame(8'h03, 1);
        `CHK("redo_needed", 1'b0, redo_needed)
        $display("test dedicated pin done");
        for (int q = 0; q < 3; q++) begin
            {quad, four} <= q[1:0];
            exp_q.push_back(2'b10);
            pulse(1'b1, 60);
            wait_ready(CP + 100);
        end
        for (int q = 0; q < 2; q++) begin
            {vpin, nvpin} <= q[0] ? 2'b01 : 2'b10;
            pulse(1'b1, 60);
        end
        {quad, four, vpin, nvpin} <= 4'hF;
        fork
            frame(8'h03, 8);
            begin repeat (40) @(posedge core_clk); pulse(1'b1, 60); end
        join
        repeat (20) @(posedge core_clk);
        exp_q.push_back(2'b10);
        pulse(1'b1, 60);
        wait_ready(CP + 100);
        $display("test data3 pin done");
        begin
            logic seen;
            seen = 1'b0;
            fork
                frame(8'hEB, 1);
                repeat (150) begin @(posedge core_clk); seen |= (d3_oe === 1'b1); end
            join
            `CHK("data3 drive", 1'b1, seen)
        end
        frame(8'h99, 1);
        repeat (10) @(posedge core_clk);
        `CHK("in_reset", 1'b0, in_reset)
        frame(8'h66, 1);
        frame(8'h99, 1);
        for (int i = 0; i < 40 && in_reset !== 1'b1; i++) @(posedge core_clk);
        `CHK("in_reset", 1'b1, in_reset)
        pulse(1'b0, 60);
        wait_ready(CP * 2);
        $display("test soft reset done");
        loose = 1'b1;
        power_up_ok <= 1'b0;
        pulse(1'b0, 60);
        `CHK("full_power_up", 1'b1, full_power_up)
        $display("test failed power-up done");
        stop_test();
    end
endmodule
`default_nettype wire
